// File: src/rsi_term_decode.sv
// Input terminal function decoder for the ramp select and start interlock block.
`timescale 1ns/1ps

module rsi_term_decode #(
  parameter int NUM_TERM = 7,
  parameter int FC_W = 8
) (
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic [NUM_TERM-1:0][FC_W-1:0] term_func_code,
  input wire logic [FC_W-1:0] fc_ramp2,
  input wire logic [FC_W-1:0] fc_interlock,
  input wire logic [FC_W-1:0] fc_trip_clear,
  output logic second_ramp_select,
  output logic start_interlock,
  output logic trip_clear_input
);

  logic [NUM_TERM-1:0] hit_ramp2;
  logic [NUM_TERM-1:0] hit_ilk;
  logic [NUM_TERM-1:0] hit_clr;

  // ----------------------------------------------------------------------
  // Per-terminal match
  // ----------------------------------------------------------------------
  // Each terminal carries whichever function its code names, so any of them may serve.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
      assign hit_ramp2[gi] = term_in[gi] && (term_func_code[gi] == fc_ramp2);
      assign hit_ilk[gi] = term_in[gi] && (term_func_code[gi] == fc_interlock);
      assign hit_clr[gi] = term_in[gi] && (term_func_code[gi] == fc_trip_clear);
    end
  endgenerate

  // Two terminals with the same code simply OR together.
  assign second_ramp_select = |hit_ramp2;
  assign start_interlock = |hit_ilk;
  assign trip_clear_input = |hit_clr;

endmodule

// File: src/rsi_ramp_interlock.sv
// Package and top module of the ramp select and start interlock block.

package rsi_pkg;
  localparam int NUM_TERM = 7;
  localparam int FC_W = 8;
  localparam int TIME_W = 16;
  localparam logic [FC_W-1:0] FC_RAMP2 = 8'h09;
  localparam logic [FC_W-1:0] FC_INTERLOCK = 8'h0D;
  localparam logic [FC_W-1:0] FC_TRIP_CLEAR = 8'h12;
  localparam logic [1:0] METHOD_TERMINAL = 2'h0;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_INTERLOCK = 8'h0D;
  localparam int CLK_KHZ = 200000;
  localparam int RESET_MIN_MS = 12;
  localparam int ALARM_CLR_MS = 30;
  // Least time rounds up; the exact figure is already whole.
  localparam int RESET_MIN_CYC = (RESET_MIN_MS * CLK_KHZ + 0) / 1;
  localparam int ALARM_CLR_CYC = ALARM_CLR_MS * CLK_KHZ;
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_STOP = 3'h1,
    ST_RUN = 3'h3,
    ST_TRIP = 3'h2,
    ST_RESET = 3'h6
  } rsi_state_t;
endpackage

`timescale 1ns/1ps

module rsi_ramp_interlock #(
  parameter int RESET_MIN_CYC = rsi_pkg::RESET_MIN_CYC,
  parameter int ALARM_CLR_CYC = rsi_pkg::ALARM_CLR_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [rsi_pkg::NUM_TERM-1:0] term_in,
  input wire logic [rsi_pkg::NUM_TERM-1:0][rsi_pkg::FC_W-1:0] term_func_code,
  input wire logic run_cmd,
  input wire logic keypad_reset,
  input wire logic [1:0] ramp_switch_method,
  input wire logic [rsi_pkg::TIME_W-1:0] accel_time_primary,
  input wire logic [rsi_pkg::TIME_W-1:0] decel_time_primary,
  input wire logic [rsi_pkg::TIME_W-1:0] accel_time_secondary,
  input wire logic [rsi_pkg::TIME_W-1:0] decel_time_secondary,
  output logic [rsi_pkg::TIME_W-1:0] accel_time_active,
  output logic [rsi_pkg::TIME_W-1:0] decel_time_active,
  output logic second_ramp_active,
  output logic motor_run,
  output logic alarm_out,
  output logic [7:0] error_code
);

  localparam int CNT_W = $clog2(ALARM_CLR_CYC + 1);

  logic second_ramp_select;
  logic start_interlock;
  logic trip_clear_input;
  logic ramp2_use;
  rsi_pkg::rsi_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] hold_cnt_ff, nxt_hold_cnt;
  logic trip_ff, nxt_trip;
  logic motor_run_ff, nxt_motor_run;
  logic [7:0] error_code_ff, nxt_error_code;
  logic [rsi_pkg::TIME_W-1:0] accel_ff, nxt_accel;
  logic [rsi_pkg::TIME_W-1:0] decel_ff, nxt_decel;
  logic ramp2_ff, nxt_ramp2;

  // ----------------------------------------------------------------------
  // Terminal decode
  // ----------------------------------------------------------------------
  rsi_term_decode #(
    .NUM_TERM(rsi_pkg::NUM_TERM),
    .FC_W(rsi_pkg::FC_W)
  ) u_decode (
    .term_in(term_in),
    .term_func_code(term_func_code),
    .fc_ramp2(rsi_pkg::FC_RAMP2),
    .fc_interlock(rsi_pkg::FC_INTERLOCK),
    .fc_trip_clear(rsi_pkg::FC_TRIP_CLEAR),
    .second_ramp_select(second_ramp_select),
    .start_interlock(start_interlock),
    .trip_clear_input(trip_clear_input)
  );

  // ----------------------------------------------------------------------
  // Ramp time selection
  // ----------------------------------------------------------------------
  // The terminal is ignored unless software picked the terminal switch method.
  assign ramp2_use = second_ramp_select && (ramp_switch_method == rsi_pkg::METHOD_TERMINAL);

  // No ramp state is kept here, so a change mid-ramp lands on the next edge.
  always_comb begin
    nxt_ramp2 = ramp2_use;
    if (ramp2_use) begin
      nxt_accel = accel_time_secondary;
      nxt_decel = decel_time_secondary;
    end else begin
      nxt_accel = accel_time_primary;
      nxt_decel = decel_time_primary;
    end
  end

  // Ramp time registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      accel_ff <= '0;
      decel_ff <= '0;
      ramp2_ff <= 1'b0;
    end else begin
      accel_ff <= nxt_accel;
      decel_ff <= nxt_decel;
      ramp2_ff <= nxt_ramp2;
    end
  end

  // ----------------------------------------------------------------------
  // Run and interlock sequencer
  // ----------------------------------------------------------------------
  // Reset release counts as power-up; the first cycle after it samples the run command.
  always_comb begin
    nxt_state = state_ff;
    nxt_trip = trip_ff;
    nxt_hold_cnt = hold_cnt_ff;
    unique case (state_ff)
      rsi_pkg::ST_POWERUP: begin
        if (run_cmd && start_interlock) begin
          nxt_state = rsi_pkg::ST_TRIP;
          nxt_trip = 1'b1;
        end else if (run_cmd) begin
          nxt_state = rsi_pkg::ST_RUN;
        end else begin
          nxt_state = rsi_pkg::ST_STOP;
        end
      end
      rsi_pkg::ST_STOP: begin
        if (trip_clear_input) begin
          nxt_state = rsi_pkg::ST_RESET;
        end else if (run_cmd) begin
          nxt_state = rsi_pkg::ST_RUN;
        end
      end
      rsi_pkg::ST_RUN: begin
        if (trip_clear_input) begin
          nxt_state = rsi_pkg::ST_RESET;
        end else if (!run_cmd) begin
          nxt_state = rsi_pkg::ST_STOP;
        end
      end
      rsi_pkg::ST_TRIP: begin
        if (trip_clear_input) begin
          nxt_state = rsi_pkg::ST_RESET;
        end else if (!run_cmd) begin
          nxt_state = rsi_pkg::ST_STOP;
          nxt_trip = 1'b0;
        end else if (keypad_reset) begin
          nxt_state = rsi_pkg::ST_RUN;
          nxt_trip = 1'b0;
        end
      end
      rsi_pkg::ST_RESET: begin
        // Output stays off while held; a short pulse leaves any trip in place.
        if (hold_cnt_ff != CNT_W'(ALARM_CLR_CYC)) begin
          nxt_hold_cnt = hold_cnt_ff + 1'b1;
        end
        if (hold_cnt_ff == CNT_W'(RESET_MIN_CYC - 1)) begin
          nxt_trip = 1'b0;
        end
        if (!trip_clear_input) begin
          nxt_hold_cnt = '0;
          // A release on the edge that ends the minimum hold must not land in a cleared trip.
          if (nxt_trip) begin
            nxt_state = rsi_pkg::ST_TRIP;
          end else if (run_cmd) begin
            nxt_state = rsi_pkg::ST_RUN;
          end else begin
            nxt_state = rsi_pkg::ST_STOP;
          end
        end
      end
      default: begin
        nxt_state = rsi_pkg::ST_POWERUP;
      end
    endcase
    nxt_motor_run = (nxt_state == rsi_pkg::ST_RUN);
    nxt_error_code = nxt_trip ? rsi_pkg::ERR_INTERLOCK : rsi_pkg::ERR_NONE;
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= rsi_pkg::ST_POWERUP;
      trip_ff <= 1'b0;
      hold_cnt_ff <= '0;
      motor_run_ff <= 1'b0;
      error_code_ff <= rsi_pkg::ERR_NONE;
    end else begin
      state_ff <= nxt_state;
      trip_ff <= nxt_trip;
      hold_cnt_ff <= nxt_hold_cnt;
      motor_run_ff <= nxt_motor_run;
      error_code_ff <= nxt_error_code;
    end
  end

  assign accel_time_active = accel_ff;
  assign decel_time_active = decel_ff;
  assign second_ramp_active = ramp2_ff;
  assign motor_run = motor_run_ff;
  assign alarm_out = trip_ff;
  assign error_code = error_code_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  ramp_secondary_a: assert property (ramp2_use |=>
    (accel_time_active == $past(accel_time_secondary)) &&
    (decel_time_active == $past(decel_time_secondary)))
    else $error("Secondary ramp times not applied.");
  ramp_primary_a: assert property (!ramp2_use |=>
    (accel_time_active == $past(accel_time_primary)) && !second_ramp_active)
    else $error("Primary ramp times not restored.");
  ramp_midswitch_a: assert property (motor_run && $rose(ramp2_use) |=>
    second_ramp_active && (accel_time_active == $past(accel_time_secondary)))
    else $error("Mid-ramp switch did not take effect at once.");
  method_gate_a: assert property (
    second_ramp_select && (ramp_switch_method != rsi_pkg::METHOD_TERMINAL) |=>
    !second_ramp_active && (accel_time_active == $past(accel_time_primary)))
    else $error("Ramp select acted under the wrong switch method.");
  powerup_run_a: assert property (
    (state_ff == rsi_pkg::ST_POWERUP) && run_cmd && !start_interlock |=> motor_run)
    else $error("Run at power-up did not start the motor.");
  interlock_trip_a: assert property (
    (state_ff == rsi_pkg::ST_POWERUP) && run_cmd && start_interlock |=>
    alarm_out && !motor_run && (error_code == rsi_pkg::ERR_INTERLOCK))
    else $error("Interlock did not trip on run at power-up.");
  restart_clear_a: assert property (
    (state_ff == rsi_pkg::ST_TRIP) && alarm_out && !run_cmd && !trip_clear_input ##1
    run_cmd && !trip_clear_input |=>
    motor_run && !alarm_out)
    else $error("New run after clearing did not start.");
  reset_resume_a: assert property (
    (state_ff == rsi_pkg::ST_RESET) && !trip_clear_input && !trip_ff && run_cmd |=> motor_run)
    else $error("Reset release with run held did not resume.");
  terminal_six_a: assert property (
    term_in[6] && (term_func_code[6] == rsi_pkg::FC_RAMP2) &&
    (ramp_switch_method == rsi_pkg::METHOD_TERMINAL) |=> second_ramp_active)
    else $error("Ramp select on the last terminal ignored.");
  alarm_clear_a: assert property (
    (state_ff == rsi_pkg::ST_RESET) && (hold_cnt_ff >= CNT_W'(RESET_MIN_CYC)) |-> !alarm_out)
    else $error("Alarm still set after the reset hold time.");

  trip_seen_c: cover property (alarm_out && !run_cmd ##1 !alarm_out);
  reset_clear_c: cover property ((state_ff == rsi_pkg::ST_RESET) && alarm_out ##1 !alarm_out);
  ramp_switch_c: cover property (motor_run && $rose(second_ramp_active));
  keypad_clear_c: cover property ((state_ff == rsi_pkg::ST_TRIP) && keypad_reset ##1 motor_run);

endmodule

// File: verification/rsi_switch_model.sv
// Behavioural model of the switches and controller that drive the input terminals.
`timescale 1ns/1ps

module rsi_switch_model (
  input wire logic sys_clk,
  output logic [rsi_pkg::NUM_TERM-1:0] term_in,
  output logic run_cmd,
  output logic keypad_reset
);
  // All contacts start open, so nothing is asserted before the first call.
  initial begin
    term_in = '0;
    run_cmd = 1'b0;
    keypad_reset = 1'b0;
  end

  // Every change lands on a falling edge, half a cycle clear of the sampling edge.
  task automatic set_term(input int idx, input logic lvl);
    @(negedge sys_clk);
    term_in[idx] = lvl;
  endtask

  task automatic set_run(input logic lvl);
    @(negedge sys_clk);
    run_cmd = lvl;
  endtask

  // A reset contact held for the given count; a short count shows a pulse that is too brief.
  task automatic hold_term(input int idx, input int cycles);
    set_term(idx, 1'b1);
    repeat (cycles) @(negedge sys_clk);
    term_in[idx] = 1'b0;
  endtask

  task automatic key_press();
    @(negedge sys_clk);
    keypad_reset = 1'b1;
    @(negedge sys_clk);
    keypad_reset = 1'b0;
  endtask
endmodule

// File: verification/rsi_ramp_interlock_tb.sv
// Self-checking testbench for the ramp select and start interlock block.
`timescale 1ns/1ps

module rsi_ramp_interlock_tb;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  // Short hold counts keep the run brief; the minimum hold must stay below the alarm limit.
  localparam int RST_CYC = 8;
  localparam int ALM_CYC = 20;
  localparam int T_RST = 0;
  localparam int T_R2 = 2;
  localparam int T_IL = 5;
  localparam int T_ALT = 6;
  localparam logic [15:0] ACC1 = 16'h0100;
  localparam logic [15:0] DEC1 = 16'h0200;
  localparam logic [15:0] ACC2 = 16'h0A5C;
  localparam logic [15:0] DEC2 = 16'h3C7E;
  logic sys_clk;
  logic srst;
  logic [rsi_pkg::NUM_TERM-1:0] term_in;
  logic [rsi_pkg::NUM_TERM-1:0][rsi_pkg::FC_W-1:0] term_func_code;
  logic run_cmd;
  logic keypad_reset;
  logic [1:0] ramp_switch_method;
  logic [15:0] accel_time_active;
  logic [15:0] decel_time_active;
  logic second_ramp_active;
  logic motor_run;
  logic alarm_out;
  logic [7:0] error_code;
  int mismatches = 0;
  int num_checks = 0;

  rsi_switch_model SW (.sys_clk(sys_clk), .term_in(term_in), .run_cmd(run_cmd),
    .keypad_reset(keypad_reset));

  rsi_ramp_interlock #(.RESET_MIN_CYC(RST_CYC), .ALARM_CLR_CYC(ALM_CYC)) DUT (
    .sys_clk(sys_clk), .srst(srst), .term_in(term_in), .term_func_code(term_func_code),
    .run_cmd(run_cmd), .keypad_reset(keypad_reset), .ramp_switch_method(ramp_switch_method),
    .accel_time_primary(ACC1), .decel_time_primary(DEC1), .accel_time_secondary(ACC2),
    .decel_time_secondary(DEC2), .accel_time_active(accel_time_active),
    .decel_time_active(decel_time_active), .second_ramp_active(second_ramp_active),
    .motor_run(motor_run), .alarm_out(alarm_out), .error_code(error_code));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ramp_chk(input logic sec);
    check(accel_time_active, sec ? ACC2 : ACC1);
    check(decel_time_active, sec ? DEC2 : DEC1);
    check({15'h0000, second_ramp_active}, {15'h0000, sec});
  endtask

  task automatic st_chk(input logic run, input logic alm, input logic [7:0] err);
    check({15'h0000, motor_run}, {15'h0000, run});
    check({15'h0000, alarm_out}, {15'h0000, alm});
    check({8'h00, error_code}, {8'h00, err});
  endtask

  // Power-up: run and interlock levels are set while reset is held, as the decision samples them.
  task automatic power_up(input logic run, input logic lock);
    @(negedge sys_clk);
    srst = 1'b1;
    SW.set_run(run);
    SW.set_term(T_IL, lock);
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    ramp_switch_method = rsi_pkg::METHOD_TERMINAL;
    term_func_code = '0;
    term_func_code[T_RST] = rsi_pkg::FC_TRIP_CLEAR;
    term_func_code[T_R2] = rsi_pkg::FC_RAMP2;
    term_func_code[T_IL] = rsi_pkg::FC_INTERLOCK;
    power_up(1'b1, 1'b0);
    st_chk(1'b1, 1'b0, rsi_pkg::ERR_NONE);
    ramp_chk(1'b0);
    SW.set_term(T_R2, 1'b1);
    repeat (2) @(negedge sys_clk);
    ramp_chk(1'b1);
    SW.set_term(T_R2, 1'b0);
    repeat (2) @(negedge sys_clk);
    ramp_chk(1'b0);
    ramp_switch_method = 2'h1;
    SW.set_term(T_R2, 1'b1);
    repeat (2) @(negedge sys_clk);
    ramp_chk(1'b0);
    ramp_switch_method = rsi_pkg::METHOD_TERMINAL;
    repeat (2) @(negedge sys_clk);
    ramp_chk(1'b1);
    SW.set_term(T_R2, 1'b0);
    // Moving the function to another terminal must leave the old one without effect.
    term_func_code[T_R2] = 8'h00;
    term_func_code[T_ALT] = rsi_pkg::FC_RAMP2;
    SW.set_term(T_R2, 1'b1);
    repeat (2) @(negedge sys_clk);
    ramp_chk(1'b0);
    SW.set_term(T_ALT, 1'b1);
    repeat (2) @(negedge sys_clk);
    ramp_chk(1'b1);
    power_up(1'b1, 1'b1);
    st_chk(1'b0, 1'b1, rsi_pkg::ERR_INTERLOCK);
    SW.set_run(1'b0);
    repeat (2) @(negedge sys_clk);
    st_chk(1'b0, 1'b0, rsi_pkg::ERR_NONE);
    SW.set_run(1'b1);
    repeat (2) @(negedge sys_clk);
    st_chk(1'b1, 1'b0, rsi_pkg::ERR_NONE);
    power_up(1'b1, 1'b1);
    SW.hold_term(T_RST, RST_CYC / 2);
    repeat (2) @(negedge sys_clk);
    st_chk(1'b0, 1'b1, rsi_pkg::ERR_INTERLOCK);
    SW.hold_term(T_RST, RST_CYC + 2);
    check({15'h0000, alarm_out}, 16'h0000);
    repeat (3) @(negedge sys_clk);
    st_chk(1'b1, 1'b0, rsi_pkg::ERR_NONE);
    // The reset terminal stops a running motor with no trip, and release resumes it.
    SW.set_term(T_RST, 1'b1);
    repeat (2) @(negedge sys_clk);
    st_chk(1'b0, 1'b0, rsi_pkg::ERR_NONE);
    SW.set_term(T_RST, 1'b0);
    repeat (2) @(negedge sys_clk);
    st_chk(1'b1, 1'b0, rsi_pkg::ERR_NONE);
    // A hold of exactly the minimum length must clear the trip and resume the run.
    power_up(1'b1, 1'b1);
    SW.hold_term(T_RST, RST_CYC);
    repeat (2) @(negedge sys_clk);
    st_chk(1'b1, 1'b0, rsi_pkg::ERR_NONE);
    power_up(1'b1, 1'b1);
    SW.key_press();
    repeat (2) @(negedge sys_clk);
    st_chk(1'b1, 1'b0, rsi_pkg::ERR_NONE);
    end_of_test();
  end

  // The whole sequence needs under two hundred cycles; the limit leaves a wide margin.
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule
